/* File: core/ifl_core.sv */
// Interrupt request flags, enables, vector selection and low voltage detector control.
// Assumes the core accesses registers synchronously on clk_sys and that all event inputs
// are one-cycle pulses synchronous to clk_sys; the supply comparator level is already synchronous.
`timescale 1ns/1ps
`include "ifl_map.svh"

module ifl_core #(
	parameter int VARIANT = 2
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port from the core
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Vector port to the core
	output logic irq_req,
	output ifl_pkg::ifl_vec_t irq_vector,
	input wire logic irq_ack,
	// External pin and request sources
	input wire logic pin_level,
	input wire logic touch_event,
	input wire logic protection_event,
	input wire logic timer0_cmp_a_event,
	input wire logic timer0_cmp_p_event,
	input wire logic compact0_cmp_a_event,
	input wire logic compact0_cmp_p_event,
	input wire logic uart_event,
	input wire logic eeprom_event,
	input wire logic serial_module_event,
	input wire logic time_base0_event,
	input wire logic time_base1_event,
	input wire logic converter_event,
	input wire logic timer1_cmp_a_event,
	input wire logic timer1_cmp_p_event,
	input wire logic compact1_cmp_a_event,
	input wire logic compact1_cmp_p_event,
	// Analog detector side
	input wire logic supply_below_thresh,
	output logic detector_on,
	output logic reference_on,
	output logic [2:0] threshold_level,
	// Power management
	input wire logic sleep_mode,
	output logic wake_req
);
	// Variant shaping of the multi-function bits
	localparam logic [3:0] MF_MASK = (VARIANT == 2) ? `IFL_MFI_MASK_L :
		(VARIANT == 1) ? `IFL_MFI_MASK_M : `IFL_MFI_MASK_S;
	localparam logic MF_IMPL = (VARIANT != 0);
	localparam ifl_pkg::ifl_src_t SRC_IMPL = {4'hF, MF_IMPL, 10'h3FF};
	localparam logic [`IFL_LVD_CNT_W-1:0] LVD_CYC = `IFL_LVD_CNT_W'(`IFL_LVD_DELAY_CYC);

	// State
	ifl_pkg::ifl_edge_t edge_q;
	logic emi_q, emi_d;
	ifl_pkg::ifl_src_t en_q, en_d, flag_q, flag_d;
	logic [3:0] mfi_en_q, mfi_en_d, mfi_flag_q, mfi_flag_d;
	logic lvd_en_q, ref_en_q;
	logic [2:0] thr_q;
	logic pin_prev_q;
	logic [`IFL_LVD_CNT_W-1:0] lv_cnt_q;
	logic irq_req_q;
	ifl_pkg::ifl_vec_t irq_vec_q, irq_vec_d;
	logic [7:0] rdata_q;
	logic wake_q;

	// Register write strobes
	wire wr_edge = reg_wr & (reg_addr == `IFL_OFS_EDGE);
	wire wr_c0 = reg_wr & (reg_addr == `IFL_OFS_CTL0);
	wire wr_c1 = reg_wr & (reg_addr == `IFL_OFS_CTL1);
	wire wr_c2 = reg_wr & (reg_addr == `IFL_OFS_CTL2);
	wire wr_c3 = reg_wr & (reg_addr == `IFL_OFS_CTL3);
	wire wr_mfi = reg_wr & (reg_addr == `IFL_OFS_MFI);
	wire wr_lvd = reg_wr & (reg_addr == `IFL_OFS_LVD);
	wire [7:0] w = reg_wdata;

	// bit placement
	// Software write mask and values, request index 14 down to 0
	wire ifl_pkg::ifl_src_t sw_mask = {{4{wr_c3}}, {4{wr_c2}}, {4{wr_c1}}, {3{wr_c0}}};
	wire ifl_pkg::ifl_src_t sw_fval = {w[4], w[5], w[7], w[6], w[4], w[5], w[6], w[7],
		w[4], w[5], w[6], w[7], w[6], w[5], w[4]};
	wire ifl_pkg::ifl_src_t sw_eval = {w[0], w[1], w[3], w[2], w[0], w[1], w[2], w[3],
		w[0], w[1], w[2], w[3], w[3], w[2], w[1]};

	wire pin_rise = pin_level & ~pin_prev_q;
	wire pin_fall = ~pin_level & pin_prev_q;
	wire pin_event = (edge_q == ifl_pkg::IFL_EDGE_RISE) ? pin_rise :
		(edge_q == ifl_pkg::IFL_EDGE_FALL) ? pin_fall :
		(edge_q == ifl_pkg::IFL_EDGE_BOTH) ? (pin_rise | pin_fall) : 1'b0;

	// multi-function sub-requests feed the shared request
	wire [3:0] mfi_set = {compact1_cmp_a_event, compact1_cmp_p_event, timer1_cmp_a_event,
		timer1_cmp_p_event} & MF_MASK;
	wire mf_event = |(mfi_set & mfi_en_q);

	// raw, unfiltered comparator gated by the enable
	wire supply_low_status = lvd_en_q & supply_below_thresh;
	// request only after the delay count of continuous low status
	wire lv_event = supply_low_status & (lv_cnt_q == LVD_CYC - 1'b1);

	// events set flags whatever the request enables say; the multi flag needs an enabled sub-request
	wire ifl_pkg::ifl_src_t set_ev = {lv_event, converter_event, time_base1_event, time_base0_event,
		mf_event, serial_module_event, eeprom_event, uart_event,
		compact0_cmp_p_event, compact0_cmp_a_event, timer0_cmp_p_event, timer0_cmp_a_event,
		protection_event, touch_event, pin_event};

	// Serviced request flag is dropped on acknowledge
	wire ifl_pkg::ifl_src_t ack_clr = irq_ack ? (`IFL_NSRC'(1) << irq_vec_q) : `IFL_RST_SRC;

	// Next flag and enable values; a set in the same cycle as a clear wins
	assign flag_d = (((flag_q & ~sw_mask & ~ack_clr) | (sw_fval & sw_mask)) | set_ev) & SRC_IMPL;
	assign en_d = ((en_q & ~sw_mask) | (sw_eval & sw_mask)) & SRC_IMPL;
	assign mfi_flag_d = (((mfi_flag_q & ~{4{wr_mfi}}) | (w[7:4] & {4{wr_mfi}})) | mfi_set) & MF_MASK;
	assign mfi_en_d = (wr_mfi ? w[3:0] : mfi_en_q) & MF_MASK;

	// acknowledge beats a software write of the global enable
	assign emi_d = irq_ack ? 1'b0 : (wr_c0 ? w[0] : emi_q);

	// lowest index among pending enabled requests
	function automatic ifl_pkg::ifl_vec_t ifl_pick(input ifl_pkg::ifl_src_t pend);
		ifl_pkg::ifl_vec_t v;
		v = 4'h0;
		for (int i = `IFL_NSRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				v = 4'(i);
			end
		end
		return v;
	endfunction

	wire ifl_pkg::ifl_src_t pend_d = flag_d & en_d;
	assign irq_vec_d = ifl_pick(pend_d);

	// Readback assembly; unmapped offsets read zero
	wire [7:0] rd_edge = {6'h00, edge_q};
	wire [7:0] rd_c0 = {1'b0, flag_q[2:0], en_q[2:0], emi_q};
	wire [7:0] rd_c1 = {flag_q[3], flag_q[4], flag_q[5], flag_q[6], en_q[3], en_q[4], en_q[5], en_q[6]};
	wire [7:0] rd_c2 = {flag_q[7], flag_q[8], flag_q[9], flag_q[10], en_q[7], en_q[8], en_q[9], en_q[10]};
	wire [7:0] rd_c3 = {flag_q[12], flag_q[11], flag_q[13], flag_q[14],
		en_q[12], en_q[11], en_q[13], en_q[14]};
	wire [7:0] rd_mfi = {mfi_flag_q, mfi_en_q};
	wire [7:0] rd_lvd = {2'h0, supply_low_status, lvd_en_q, ref_en_q, thr_q};
	wire [7:0] rd_byte = (reg_addr == `IFL_OFS_EDGE) ? rd_edge :
		(reg_addr == `IFL_OFS_CTL0) ? rd_c0 :
		(reg_addr == `IFL_OFS_CTL1) ? rd_c1 :
		(reg_addr == `IFL_OFS_CTL2) ? rd_c2 :
		(reg_addr == `IFL_OFS_CTL3) ? rd_c3 :
		(reg_addr == `IFL_OFS_MFI) ? rd_mfi :
		(reg_addr == `IFL_OFS_LVD) ? rd_lvd : `IFL_RST_BYTE;

	// out-of-range codes are held at the top level, so only five levels exist
	wire [2:0] thr_wr = (w[2:0] > `IFL_LVD_THR_MAX) ? `IFL_LVD_THR_MAX : w[2:0];

	// Flags, enables and vector state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_q <= `IFL_RST_SRC;
			en_q <= `IFL_RST_SRC;
			mfi_flag_q <= `IFL_RST_MFI;
			mfi_en_q <= `IFL_RST_MFI;
			emi_q <= 1'b0;
			irq_req_q <= 1'b0;
			irq_vec_q <= 4'h0;
		end else begin
			flag_q <= flag_d;
			en_q <= en_d;
			mfi_flag_q <= mfi_flag_d;
			mfi_en_q <= mfi_en_d;
			emi_q <= emi_d;
			irq_req_q <= emi_d & (|pend_d);
			irq_vec_q <= irq_vec_d;
		end
	end

	// Edge field, pin history and read data
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			edge_q <= ifl_pkg::IFL_EDGE_OFF;
			pin_prev_q <= 1'b0;
			rdata_q <= `IFL_RST_BYTE;
		end else begin
			if (wr_edge) begin
				edge_q <= ifl_pkg::ifl_edge_t'(w[1:0]);
			end
			pin_prev_q <= pin_level;
			if (reg_rd) begin
				rdata_q <= rd_byte;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lvd_en_q <= 1'b0;
			ref_en_q <= 1'b0;
			thr_q <= 3'h0;
		end else if (wr_lvd) begin
			lvd_en_q <= w[`IFL_LVD_EN];
			ref_en_q <= w[`IFL_LVD_REF];
			thr_q <= thr_wr;
		end
	end

	// delay counter; restarts whenever status falls, saturates after one request
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lv_cnt_q <= '0;
		end else if (!supply_low_status) begin
			lv_cnt_q <= '0;
		end else if (lv_cnt_q != LVD_CYC) begin
			lv_cnt_q <= lv_cnt_q + 1'b1;
		end
	end

	// wake only on a fresh low voltage flag, so a preset flag suppresses it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= sleep_mode & lv_event & ~flag_q[`IFL_SRC_LV];
		end
	end

	// Outputs; detector keeps running in sleep, nothing here looks at sleep_mode
	assign reg_rdata = rdata_q;
	assign irq_req = irq_req_q;
	assign irq_vector = irq_vec_q;
	assign detector_on = lvd_en_q;
	// reference forced on while the detector runs
	assign reference_on = ref_en_q | lvd_en_q;
	assign threshold_level = thr_q;
	assign wake_req = wake_q;

	// Helpers for the checks
	wire ifl_pkg::ifl_src_t pend_q = flag_q & en_q;
	wire ifl_pkg::ifl_src_t below_vec = (`IFL_NSRC'(1) << irq_vector) - `IFL_NSRC'(1);

	AST_EDGE_RISE: assert property (@(posedge clk_sys) disable iff (rst)
		(edge_q == ifl_pkg::IFL_EDGE_RISE && pin_rise) |=> flag_q[`IFL_SRC_PIN])
		else $error("rising pin edge did not set pin flag");
	AST_EDGE_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		(edge_q == ifl_pkg::IFL_EDGE_OFF && !flag_q[`IFL_SRC_PIN] && !wr_c0) |=> !flag_q[`IFL_SRC_PIN])
		else $error("pin flag set while edge detection off");
	AST_CTL0_READ: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == `IFL_OFS_CTL0) |=>
		(reg_rdata[7] == 1'b0 && reg_rdata[0] == $past(emi_q) && reg_rdata[6] == $past(flag_q[`IFL_SRC_PROT])))
		else $error("control 0 readback wrong");
	AST_MF_ABSENT: assert property (@(posedge clk_sys) disable iff (rst)
		(VARIANT != 0) || (!flag_q[`IFL_SRC_MULTI] && !en_q[`IFL_SRC_MULTI]))
		else $error("multi bits present on small variant");
	AST_MFI_MASK: assert property (@(posedge clk_sys) disable iff (rst)
		((mfi_flag_q & ~MF_MASK) == 4'h0) && ((mfi_en_q & ~MF_MASK) == 4'h0))
		else $error("unimplemented multi bits set");
	AST_THR_RANGE: assert property (@(posedge clk_sys) disable iff (rst)
		threshold_level <= `IFL_LVD_THR_MAX)
		else $error("threshold level beyond five levels");
	AST_STATUS_READ: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == `IFL_OFS_LVD) |=>
		reg_rdata[`IFL_LVD_STATUS] == $past(lvd_en_q & supply_below_thresh))
		else $error("status bit does not follow supply");
	AST_REF_AUTO: assert property (@(posedge clk_sys) disable iff (rst)
		detector_on |-> reference_on)
		else $error("reference off while detector on");
	AST_LV_EARLY: assert property (@(posedge clk_sys) disable iff (rst)
		(lv_cnt_q < LVD_CYC - 1'b1 && !flag_q[`IFL_SRC_LV] && !wr_c3) |=> !flag_q[`IFL_SRC_LV])
		else $error("low voltage flag set before delay");
	AST_LV_WAKE: assert property (@(posedge clk_sys) disable iff (rst)
		(sleep_mode && lv_event && !flag_q[`IFL_SRC_LV]) |=> (wake_req && flag_q[`IFL_SRC_LV]) ##1 !wake_req)
		else $error("low supply in sleep did not wake once");
	AST_FLAG_NO_EN: assert property (@(posedge clk_sys) disable iff (rst)
		touch_event |=> flag_q[`IFL_SRC_TOUCH])
		else $error("touch event lost");
	AST_GLOBAL_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		!emi_q |-> !irq_req)
		else $error("request with global enable clear");
	AST_ACK_CLEARS: assert property (@(posedge clk_sys) disable iff (rst)
		irq_ack |=> (!emi_q && !irq_req))
		else $error("acknowledge left global enable set");
	AST_PRIO: assert property (@(posedge clk_sys) disable iff (rst)
		irq_req |-> (pend_q[irq_vector] && ((pend_q & below_vec) == `IFL_RST_SRC)))
		else $error("vector not highest priority pending");

	// Enable placement per register; enables have no hardware set, so a write is their only source
	AST_EN_CTL0: assert property (@(posedge clk_sys) disable iff (rst)
		wr_c0 |=> (en_q[`IFL_SRC_PIN] == $past(w[1]) && en_q[`IFL_SRC_PROT] == $past(w[3])))
		else $error("control 0 enable placement wrong");
	AST_EN_CTL1: assert property (@(posedge clk_sys) disable iff (rst)
		wr_c1 |=> (en_q[3] == $past(w[3]) && en_q[6] == $past(w[0])))
		else $error("control 1 enable placement wrong");
	AST_EN_CTL2: assert property (@(posedge clk_sys) disable iff (rst)
		wr_c2 |=> (en_q[7] == $past(w[3]) && en_q[`IFL_SRC_MULTI] == ($past(w[0]) && MF_IMPL)))
		else $error("control 2 enable placement wrong");
	AST_EN_CTL3: assert property (@(posedge clk_sys) disable iff (rst)
		wr_c3 |=> (en_q[`IFL_SRC_LV] == $past(w[0]) && en_q[12] == $past(w[3])))
		else $error("control 3 enable placement wrong");
	AST_MFI_EN: assert property (@(posedge clk_sys) disable iff (rst)
		wr_mfi |=> (mfi_en_q == ($past(w[3:0]) & MF_MASK)))
		else $error("multi enable placement wrong");

	// Remaining edge codes, detector enable, wake source and acknowledge clear
	AST_EDGE_FALL: assert property (@(posedge clk_sys) disable iff (rst)
		(edge_q == ifl_pkg::IFL_EDGE_FALL && pin_fall) |=> flag_q[`IFL_SRC_PIN])
		else $error("falling pin edge did not set pin flag");
	AST_EDGE_BOTH: assert property (@(posedge clk_sys) disable iff (rst)
		(edge_q == ifl_pkg::IFL_EDGE_BOTH && (pin_rise || pin_fall)) |=> flag_q[`IFL_SRC_PIN])
		else $error("pin edge missed in both-edge mode");
	AST_DET_EN: assert property (@(posedge clk_sys) disable iff (rst)
		wr_lvd |=> (detector_on == $past(w[`IFL_LVD_EN])))
		else $error("detector power does not follow its enable");
	AST_WAKE_SRC: assert property (@(posedge clk_sys) disable iff (rst)
		wake_req |-> flag_q[`IFL_SRC_LV])
		else $error("wake without low voltage flag");
	AST_ACK_DROP: assert property (@(posedge clk_sys) disable iff (rst)
		(irq_ack && irq_vector == `IFL_SRC_TOUCH && !touch_event && !wr_c0) |=> !flag_q[`IFL_SRC_TOUCH])
		else $error("acknowledged touch flag not cleared");
endmodule

/* File: pkg/ifl_map.svh */
// Register offsets, field positions, reset values and timing counts of the interrupt flag block.
// Included by bare name; defines only.
`ifndef IFL_MAP_SVH
`define IFL_MAP_SVH

// Register port offsets
`define IFL_OFS_EDGE 3'h0
`define IFL_OFS_CTL0 3'h1
`define IFL_OFS_CTL1 3'h2
`define IFL_OFS_CTL2 3'h3
`define IFL_OFS_CTL3 3'h4
`define IFL_OFS_MFI 3'h5
`define IFL_OFS_LVD 3'h6

// Reset values
`define IFL_RST_BYTE 8'h00
`define IFL_RST_SRC 15'h0000
`define IFL_RST_MFI 4'h0

// Request index, also the vector number; a lower index has the higher priority
`define IFL_SRC_PIN 0
`define IFL_SRC_TOUCH 1
`define IFL_SRC_PROT 2
`define IFL_SRC_MULTI 10
`define IFL_SRC_LV 14
`define IFL_NSRC 15

// Multi-function sub-request masks per variant (large, middle, small)
`define IFL_MFI_MASK_L 4'hF
`define IFL_MFI_MASK_M 4'h3
`define IFL_MFI_MASK_S 4'h0

// Detector control fields
`define IFL_LVD_STATUS 5
`define IFL_LVD_EN 4
`define IFL_LVD_REF 3
`define IFL_LVD_THR_MAX 3'h4

// Timing: detector request delay, rounded up to whole cycles
`define IFL_CLK_MHZ 100
`define IFL_LVD_DELAY_NS 15000
`define IFL_LVD_DELAY_CYC (((`IFL_LVD_DELAY_NS * `IFL_CLK_MHZ) + 999) / 1000)
`define IFL_LVD_CNT_W 11

`endif

/* File: pkg/ifl_pkg.sv */
// Types shared by the interrupt flag block.
// Constants live in ifl_map.svh.
package ifl_pkg;
	// Edge selection for the external pin
	typedef enum logic [1:0] {
		IFL_EDGE_OFF = 2'h0,
		IFL_EDGE_RISE = 2'h1,
		IFL_EDGE_FALL = 2'h2,
		IFL_EDGE_BOTH = 2'h3
	} ifl_edge_t;
	// Vector number handed to the core
	typedef logic [3:0] ifl_vec_t;
	// One bit per primary request
	typedef logic [14:0] ifl_src_t;
endpackage

/* File: tb/ifl_cpu_model.sv */
// CPU core stand-in: takes the vector offered by the flag block and acknowledges it.
// Assumes irq_req and irq_vector are registered levels on clk_sys.
`timescale 1ns/1ps
module ifl_cpu_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Vector port
	input wire logic irq_req,
	input wire ifl_pkg::ifl_vec_t irq_vector,
	output logic irq_ack,
	// Bench control and record
	input wire logic ack_on,
	input wire logic [3:0] ack_wait,
	output ifl_pkg::ifl_vec_t last_vec,
	output logic [7:0] n_ack
);
	logic [3:0] wait_q;
	// One-cycle ack only while a request stands; a slow core first idles ack_wait cycles
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_ack <= 1'b0;
			wait_q <= 4'h0;
			last_vec <= 4'h0;
			n_ack <= 8'h00;
		end else if (irq_ack) begin
			irq_ack <= 1'b0;
			wait_q <= 4'h0;
		end else if (ack_on && irq_req) begin
			if (wait_q == ack_wait) begin
				irq_ack <= 1'b1;
				last_vec <= irq_vector;
				n_ack <= n_ack + 8'h01;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end else begin
			wait_q <= 4'h0;
		end
	end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the interrupt flag block, large variant.
// Assumes read data settles one cycle after the read strobe.
`timescale 1ns/1ps
`include "ifl_map.svh"
`define CHK(got, exp) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("[ERR] %0t got %h exp %h", $time, got, exp); \
	end \
end
module tb;
	logic clk_sys, rst, reg_wr, reg_rd, irq_ack, pin_level, supply_below_thresh, sleep_mode, ack_on;
	logic irq_req, detector_on, reference_on, wake_req;
	logic [2:0] reg_addr, threshold_level;
	logic [7:0] reg_wdata, reg_rdata, rd_val, n_ack;
	logic [3:0] ack_wait;
	logic [15:0] ev;
	ifl_pkg::ifl_vec_t irq_vector, last_vec;
	int fail_count, n_compared, cyc, wakes, n;
	// Register rows: offset, byte written, byte read back
	logic [18:0] rows [11] = '{{3'h0, 8'hFF, 8'h03}, {3'h1, 8'hFF, 8'h7F}, {3'h2, 8'hA5, 8'hA5},
		{3'h2, 8'h5A, 8'h5A}, {3'h3, 8'hFF, 8'hFF}, {3'h4, 8'hC3, 8'hC3}, {3'h4, 8'h3C, 8'h3C},
		{3'h5, 8'hFF, 8'hFF}, {3'h6, 8'hFF, 8'h1C}, {3'h6, 8'h03, 8'h03}, {3'h7, 8'hFF, 8'h00}};
	// Event index to flag place: offset in bits 5..3, bit number in 2..0
	logic [5:0] evm [16] = '{6'h0D, 6'h0E, 6'h17, 6'h16, 6'h15, 6'h14, 6'h1F, 6'h1E,
		6'h1D, 6'h26, 6'h27, 6'h25, 6'h2D, 6'h2C, 6'h2F, 6'h2E};

	ifl_core #(.VARIANT(2)) dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_ack(irq_ack), .pin_level(pin_level), .touch_event(ev[0]),
		.protection_event(ev[1]), .timer0_cmp_a_event(ev[2]), .timer0_cmp_p_event(ev[3]),
		.compact0_cmp_a_event(ev[4]), .compact0_cmp_p_event(ev[5]), .uart_event(ev[6]),
		.eeprom_event(ev[7]), .serial_module_event(ev[8]), .time_base0_event(ev[9]),
		.time_base1_event(ev[10]), .converter_event(ev[11]), .timer1_cmp_a_event(ev[12]),
		.timer1_cmp_p_event(ev[13]), .compact1_cmp_a_event(ev[14]), .compact1_cmp_p_event(ev[15]),
		.supply_below_thresh(supply_below_thresh), .detector_on(detector_on),
		.reference_on(reference_on), .threshold_level(threshold_level), .sleep_mode(sleep_mode),
		.wake_req(wake_req));
	ifl_cpu_model cpu (.clk_sys(clk_sys), .rst(rst), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_ack(irq_ack), .ack_on(ack_on), .ack_wait(ack_wait), .last_vec(last_vec), .n_ack(n_ack));

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic conclude();
		if (fail_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Cycle ceiling and wake pulse count; the whole run needs well under 20000 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (wake_req === 1'b1) wakes++;
		if (cyc == 20000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			conclude();
		end
	end
	// Register port: strobe held for exactly one sampling edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic pulse(input int i);
		@(posedge clk_sys);
		ev <= 16'h0001 << i;
		@(posedge clk_sys);
		ev <= 16'h0000;
	endtask
	task automatic pin(input logic v);
		@(posedge clk_sys);
		pin_level <= v;
		@(posedge clk_sys);
	endtask

	initial begin
		{reg_wr, reg_rd, pin_level, supply_below_thresh, sleep_mode, ack_on} = 6'h00;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		ev = 16'h0000;
		ack_wait = 4'h0;
		rst = 1'b1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		// Layouts, read-only status, threshold clamp, unmapped offset
		foreach (rows[i]) begin
			wr(rows[i][18:16], rows[i][15:8]);
			rd(rows[i][18:16]);
			`CHK(rd_val, rows[i][7:0])
			wr(rows[i][18:16], 8'h00);
		end
		// Every event input sets its own flag with all enables clear
		foreach (evm[i]) begin
			pulse(i);
			rd(evm[i][5:3]);
			`CHK(rd_val, 8'h01 << evm[i][2:0])
			wr(evm[i][5:3], 8'h00);
		end
		// enabled sub-request raises the multi flag
		wr(`IFL_OFS_MFI, 8'h01);
		pulse(13);
		rd(`IFL_OFS_CTL2);
		`CHK(rd_val, 8'h10)
		wr(`IFL_OFS_CTL2, 8'h00);
		wr(`IFL_OFS_MFI, 8'h00);
		// each edge code against a rising then a falling pin
		for (int s = 0; s < 4; s++) begin
			wr(`IFL_OFS_EDGE, 8'(s));
			wr(`IFL_OFS_CTL0, 8'h00);
			pin(1'b1);
			rd(`IFL_OFS_CTL0);
			`CHK(rd_val[4], s[0])
			wr(`IFL_OFS_CTL0, 8'h00);
			pin(1'b0);
			rd(`IFL_OFS_CTL0);
			`CHK(rd_val[4], s[1])
		end
		// flags latch but nothing is offered
		wr(`IFL_OFS_EDGE, 8'h01);
		wr(`IFL_OFS_CTL0, 8'h01);
		pulse(0);
		rd(`IFL_OFS_CTL0);
		`CHK(rd_val, 8'h21)
		`CHK(irq_req, 1'b0)
		wr(`IFL_OFS_CTL0, 8'h26);
		pin(1'b1);
		rd(`IFL_OFS_CTL0);
		`CHK(rd_val, 8'h36)
		`CHK(irq_req, 1'b0)
		// pin beats touch, ack drops global, later request still latches
		ack_on = 1'b1;
		wr(`IFL_OFS_CTL0, 8'h37);
		for (n = 0; n < 30 && n_ack !== 8'h01; n++) @(posedge clk_sys);
		`CHK(last_vec, 4'h0)
		`CHK(n_ack, 8'h01)
		pulse(1);
		rd(`IFL_OFS_CTL0);
		`CHK(rd_val, 8'h66)
		`CHK(irq_req, 1'b0)
		ack_wait = 4'h5;
		wr(`IFL_OFS_CTL0, 8'h67);
		for (n = 0; n < 30 && n_ack !== 8'h02; n++) @(posedge clk_sys);
		`CHK(last_vec, 4'h1)
		`CHK(n_ack, 8'h02)
		ack_on <= 1'b0;
		wr(`IFL_OFS_CTL0, 8'h00);
		// low supply in sleep wakes after the fixed delay
		wr(`IFL_OFS_LVD, 8'h12);
		@(posedge clk_sys);
		supply_below_thresh <= 1'b1;
		sleep_mode <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (wake_req !== 1'b1 && n < 1600);
		`CHK(n, `IFL_LVD_DELAY_CYC)
		// status read only after the detector has long settled
		rd(`IFL_OFS_LVD);
		`CHK(rd_val, 8'h32)
		`CHK({detector_on, reference_on, threshold_level}, 5'h1A)
		rd(`IFL_OFS_CTL3);
		`CHK(rd_val, 8'h10)
		// preset flag suppresses a second wake
		wr(`IFL_OFS_CTL3, 8'h10);
		n = wakes;
		@(posedge clk_sys);
		supply_below_thresh <= 1'b0;
		@(posedge clk_sys);
		supply_below_thresh <= 1'b1;
		repeat (1600) @(posedge clk_sys);
		`CHK(wakes, n)
		wr(`IFL_OFS_LVD, 8'h02);
		rd(`IFL_OFS_LVD);
		`CHK(rd_val, 8'h02)
		`CHK({detector_on, reference_on}, 2'h0)
		sleep_mode <= 1'b0;
		// Mid-run reset clears every register
		wr(`IFL_OFS_CTL1, 8'hFF);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0]);
			`CHK(rd_val, 8'h00)
		end
		conclude();
	end
endmodule
